// ### inc/timer_cfg.svh
// Offsets, field positions and reset values of the capture/compare timer
`ifndef TIMER_CFG_SVH
`define TIMER_CFG_SVH

// ----------------------------------------------------------------
// Register byte addresses and per-channel register indices
// ----------------------------------------------------------------
`define OFF_TIMER_CTRL 8'h00
`define OFF_COUNTER    8'h04
`define OFF_MODULO     8'h08
`define OFF_CH_BASE    8'h0c
`define CH_STRIDE      8'h0c
`define CH_REG_CTRL    2'h0
`define CH_REG_HIGH    2'h1
`define CH_REG_LOW     2'h2

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define T_OVF_FLAG  7
`define T_OVF_IE    6
`define T_HALT      5
`define T_CNT_RST   4
`define C_FLAG      7
`define C_IE        6
`define C_BUF       5
`define C_PRIMARY   4
`define C_ELS_HI    3
`define C_ELS_LO    2
`define C_TOV       1
`define C_MAX       0

// ----------------------------------------------------------------
// Reset values and the external clock rate code
// ----------------------------------------------------------------
`define HALT_RST    1'b1
`define MODULO_RST  16'hffff
`define PS_EXT      3'h7

`endif

// ### inc/timer_pkg.sv
// Types shared by the capture/compare timer
package timer_pkg;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} apb_rsp_t;

	typedef struct packed {
		logic        flag;
		logic        arm;
		logic        ie;
		logic        msb;
		logic        msa;
		logic [1:0]  els;
		logic        tov;
		logic        maxb;
		logic        max_eff;
		logic [15:0] val;
		logic        cap_blk;
		logic        cmp_blk;
		logic        pin;
		logic        pin_prev;
	} chan_t;

	typedef struct packed {
		chan_t [1:0] ch;
		logic [15:0] cnt;
		logic [15:0] mod;
		logic [6:0]  presc;
		logic [2:0]  ps;
		logic        halt;
		logic        toie;
		logic        tof;
		logic        tof_arm;
		logic        ext_prev;
		logic        act_sel;
		logic        wr_sel;
		logic [31:0] prdata;
	} state_t;

endpackage : timer_pkg

// ### rtl/timer_capture_compare_channels.sv
// Two-channel capture/compare timer with APB register access
//
// The placing of the registers and the APB register port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "timer_cfg.svh"

module timer_capture_compare_channels
	import timer_pkg::*;
(
	input  wire logic       core_clk,
	input  wire logic       rst_b,
	input  wire apb_req_t   apb_req,
	output var  apb_rsp_t   apb_rsp,
	input  wire logic [1:0] channel_pin_in,
	input  wire logic       external_timer_clock,
	output var  logic [1:0] channel_pin_out,
	output var  logic [1:0] channel_pin_oe,
	output var  logic [1:0] channel_irq
);

	// ------------------------------------------------------------
	// Helper functions
	// ------------------------------------------------------------

	// Divider tap: low ps bits of the prescaler all ones
	function automatic logic rate_tick(input logic [2:0] ps,
		input logic [6:0] presc, input logic ext);
		logic [6:0] mask;
		mask = 7'h7f >> (3'h7 - ps);
		if (ps == `PS_EXT)
			rate_tick = ext;
		else
			rate_tick = ((presc & mask) == mask);
	endfunction : rate_tick

	function automatic logic is_capture(input chan_t c);
		is_capture = !c.msb && !c.msa && (c.els != 2'b00);
	endfunction : is_capture

	function automatic logic is_compare(input chan_t c);
		is_compare = c.msb || c.msa;
	endfunction : is_compare

	// Edge qualifier for capture, current sample against last
	function automatic logic edge_match(input logic [1:0] els,
		input logic cur, input logic prev);
		edge_match = (els[0] && cur && !prev) ||
			(els[1] && !cur && prev);
	endfunction : edge_match

	// Pin action on compare
	function automatic logic cmp_action(input logic [1:0] els,
		input logic pin);
		unique case (els)
			2'b01:   cmp_action = ~pin;
			2'b10:   cmp_action = 1'b0;
			2'b11:   cmp_action = 1'b1;
			2'b00:   cmp_action = pin;
		endcase
	endfunction : cmp_action

	function automatic logic [7:0] chan_addr(input logic i,
		input logic [1:0] r);
		chan_addr = `OFF_CH_BASE + (i ? `CH_STRIDE : 8'h00)
			+ {4'h0, r, 2'b00};
	endfunction : chan_addr

	function automatic logic mapped(input logic [7:0] a);
		mapped = (a == `OFF_TIMER_CTRL) || (a == `OFF_COUNTER) ||
			(a == `OFF_MODULO) ||
			((a >= `OFF_CH_BASE) && (a <= chan_addr(1'b1, 2'h2))
			&& (a[1:0] == 2'b00));
	endfunction : mapped

	function automatic logic [7:0] ctrl_byte(input chan_t c);
		ctrl_byte = {c.flag, c.ie, c.msb, c.msa, c.els, c.tov,
			c.maxb};
	endfunction : ctrl_byte

	// ------------------------------------------------------------
	// State and working signals
	// ------------------------------------------------------------
	state_t      st;
	state_t      next_st;
	chan_t       c;
	logic        tick;
	logic        ovf;
	logic        ext_rise;
	logic        acc;
	logic        wr;
	logic        setup_rd;
	logic        cnt_rst_wr;
	logic        buf_alt;
	logic [15:0] cv;
	logic        blk;
	logic [1:0]  live;
	logic [1:0]  cap_ev;
	logic [1:0]  cmp_ev;
	logic [7:0]  d;

	// Bus phases; slave always ready, no wait states
	assign acc      = apb_req.psel && apb_req.penable;
	assign wr       = acc && apb_req.pwrite;
	assign setup_rd = apb_req.psel && !apb_req.penable &&
		!apb_req.pwrite;
	assign d        = apb_req.pwdata[7:0];
	assign cnt_rst_wr = wr && (apb_req.paddr == `OFF_TIMER_CTRL) &&
		d[`T_CNT_RST];

	// Read data from the flop; ready constant, error decoded from the address
	assign apb_rsp.prdata  = st.prdata;
	assign apb_rsp.pready  = 1'b1;
	assign apb_rsp.pslverr = acc && !mapped(apb_req.paddr);

	// Pins and requests; ignored odd channel drives nothing
	always_comb
	begin
		for (int i = 0; i < 2; i++)
		begin
			channel_pin_out[i] = st.ch[i].pin;
			channel_pin_oe[i]  = live[i] &&
				(st.ch[i].els != 2'b00);
			channel_irq[i]     = st.ch[i].flag &&
				st.ch[i].ie;
		end
	end

	// ------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------
	always_comb
	begin
		next_st = st;
		c       = st.ch[0];
		cv      = 16'h0000;
		blk     = 1'b0;
		live    = 2'b11;
		cap_ev  = 2'b00;
		cmp_ev  = 2'b00;
		buf_alt = st.ch[0].msb && st.act_sel;

		// Counter clock: divider taps or external pin edge
		ext_rise = external_timer_clock && !st.ext_prev;
		next_st.ext_prev = external_timer_clock;
		tick = !st.halt && rate_tick(st.ps, st.presc, ext_rise);
		ovf  = tick && (st.cnt == st.mod);
		if (!st.halt)
			next_st.presc = st.presc + 7'h01;
		if (tick)
			next_st.cnt = ovf ? 16'h0000 : st.cnt + 16'h0001;
		if (ovf)
		begin
			next_st.tof     = 1'b1;
			next_st.tof_arm = 1'b0;
			next_st.act_sel = st.wr_sel;
		end

		// Channels evaluated one by one; paired channel 0 may use channel 1's value and hold
		for (int i = 0; i < 2; i++)
		begin
			c = st.ch[i];
			live[i] = !(i == 1 && st.ch[0].msb);
			cv  = (i == 0 && buf_alt) ? st.ch[1].val : c.val;
			blk = (i == 0 && buf_alt) ? st.ch[1].cmp_blk
				: c.cmp_blk;
			next_st.ch[i].pin_prev = channel_pin_in[i];
			// Halted counter inhibits captures
			cap_ev[i] = live[i] && is_capture(c) && !st.halt &&
				!c.cap_blk &&
				edge_match(c.els, channel_pin_in[i],
				c.pin_prev);
			cmp_ev[i] = live[i] && is_compare(c) && tick &&
				(next_st.cnt == cv) && !blk;
			if (cap_ev[i])
				next_st.ch[i].val = st.cnt;
			if (cap_ev[i] || cmp_ev[i])
			begin
				next_st.ch[i].flag = 1'b1;
				next_st.ch[i].arm  = 1'b0;
			end
			// Preset level is the inverted primary bit while pin released
			if (c.els == 2'b00)
				next_st.ch[i].pin = ~c.msa;
			else if (is_compare(c) && c.tov && ovf)
				next_st.ch[i].pin = c.max_eff ? ~c.els[0]
					: ~c.pin;
			else if (cmp_ev[i] && !(c.tov && c.max_eff))
				next_st.ch[i].pin = cmp_action(c.els, c.pin);
			// Full duty only changes at a period boundary
			if (ovf)
				next_st.ch[i].max_eff = c.maxb;
		end

		// Read data latched in setup; counter read has no side
		// effect on counting
		if (setup_rd)
		begin
			next_st.prdata = 32'h0000_0000;
			if (apb_req.paddr == `OFF_TIMER_CTRL)
				next_st.prdata[7:0] = {st.tof, st.toie, st.halt,
					1'b0, 1'b0, st.ps};
			if (apb_req.paddr == `OFF_COUNTER)
				next_st.prdata[15:0] = st.cnt;
			if (apb_req.paddr == `OFF_MODULO)
				next_st.prdata[15:0] = st.mod;
			for (int i = 0; i < 2; i++)
			begin
				if (apb_req.paddr == chan_addr(i[0], `CH_REG_CTRL))
					next_st.prdata[7:0] = ctrl_byte(st.ch[i]);
				if (apb_req.paddr == chan_addr(i[0], `CH_REG_HIGH))
					next_st.prdata[7:0] = st.ch[i].val[15:8];
				if (apb_req.paddr == chan_addr(i[0], `CH_REG_LOW))
					next_st.prdata[7:0] = st.ch[i].val[7:0];
			end
		end

		// Timer control register access
		if (acc && apb_req.paddr == `OFF_TIMER_CTRL)
		begin
			if (apb_req.pwrite)
			begin
				next_st.toie = d[`T_OVF_IE];
				next_st.halt = d[`T_HALT];
				next_st.ps   = d[2:0];
				if (!d[`T_OVF_FLAG] && st.tof_arm && !ovf)
					next_st.tof = 1'b0;
				next_st.tof_arm = 1'b0;
				if (d[`T_CNT_RST])
				begin
					next_st.cnt   = 16'h0000;
					next_st.presc = 7'h00;
				end
			end
			else if (st.prdata[`T_OVF_FLAG])
				next_st.tof_arm = !ovf;
		end
		if (wr && apb_req.paddr == `OFF_MODULO)
			next_st.mod = apb_req.pwdata[15:0];

		// Channel register accesses
		for (int i = 0; i < 2; i++)
		begin
			c = st.ch[i];
			if (acc && apb_req.paddr == chan_addr(i[0], `CH_REG_CTRL))
			begin
				if (apb_req.pwrite)
				begin
					next_st.ch[i].ie   = d[`C_IE];
					next_st.ch[i].msb  = (i == 0) && d[`C_BUF];
					next_st.ch[i].msa  = d[`C_PRIMARY];
					next_st.ch[i].els  = d[`C_ELS_HI:`C_ELS_LO];
					next_st.ch[i].tov  = d[`C_TOV];
					next_st.ch[i].maxb = d[`C_MAX];
					if (!d[`C_FLAG] && c.arm &&
						!(cap_ev[i] || cmp_ev[i]))
						next_st.ch[i].flag = 1'b0;
					next_st.ch[i].arm = 1'b0;
				end
				else if (st.prdata[`C_FLAG])
					next_st.ch[i].arm = !(cap_ev[i] || cmp_ev[i]);
			end
			if (acc && apb_req.paddr == chan_addr(i[0], `CH_REG_HIGH))
			begin
				if (apb_req.pwrite)
				begin
					next_st.ch[i].val[15:8] = d;
					if (is_compare(c))
						next_st.ch[i].cmp_blk = 1'b1;
				end
				else if (!is_compare(c))
					next_st.ch[i].cap_blk = 1'b1;
			end
			if (acc && apb_req.paddr == chan_addr(i[0], `CH_REG_LOW))
			begin
				if (apb_req.pwrite)
				begin
					next_st.ch[i].val[7:0] = d;
					next_st.ch[i].cmp_blk  = 1'b0;
					if (st.ch[0].msb)
						next_st.wr_sel = i[0];
				end
				else
					next_st.ch[i].cap_blk = 1'b0;
			end
		end

		// Unpaired mode always uses the even channel's value
		if (!next_st.ch[0].msb)
		begin
			next_st.act_sel = 1'b0;
			next_st.wr_sel  = 1'b0;
		end
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			st      <= '0;
			st.halt <= `HALT_RST;
			st.mod  <= `MODULO_RST;
		end
		else
			st <= next_st;
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	sequence flag_read_s;
		st.ch[0].arm && !cap_ev[0] && !cmp_ev[0];
	endsequence
	sequence zero_write_s;
		wr && apb_req.paddr == chan_addr(1'b0, `CH_REG_CTRL) &&
			!d[`C_FLAG];
	endsequence

	halt_hold_a: assert property (st.halt && !cnt_rst_wr
		|=> $stable(st.cnt)) else $error("counter moved while halted");
	wrap_zero_a: assert property (ovf && !cnt_rst_wr
		|=> st.cnt == 16'h0000 && st.tof)
		else $error("no restart from zero at modulo");
	cap_copy_a: assert property (cap_ev[1] && !wr
		|=> st.ch[1].val == $past(st.cnt) && st.ch[1].flag)
		else $error("capture did not copy counter");
	cap_block_a: assert property (st.ch[1].cap_blk
		|-> !cap_ev[1]) else $error("capture while high byte held");
	cmp_block_a: assert property (st.ch[0].cmp_blk && !buf_alt
		|-> !cmp_ev[0]) else $error("compare while high byte held");
	ovf_first_a: assert property (ovf && st.ch[0].tov &&
		is_compare(st.ch[0]) && !st.ch[0].max_eff &&
		st.ch[0].els != 2'b00
		|=> st.ch[0].pin != $past(st.ch[0].pin))
		else $error("overflow toggle lost to compare");
	flag_keep_a: assert property (st.ch[0].flag &&
		(cap_ev[0] || cmp_ev[0]) |=> st.ch[0].flag)
		else $error("event lost during flag clear");
	flag_clear_a: assert property (flag_read_s ##0 zero_write_s
		|=> !st.ch[0].flag) else $error("flag clear sequence failed");
	pin_free_a: assert property (st.ch[0].msb
		|-> !channel_pin_oe[1]) else $error("odd pin driven in pair");
	preset_lvl_a: assert property (st.ch[0].els == 2'b00
		|=> st.ch[0].pin == !$past(st.ch[0].msa))
		else $error("preset level wrong");
	irq_drop_a: assert property ($fell(st.ch[0].flag)
		|-> !channel_irq[0] && $past(st.ch[0].arm))
		else $error("request outlived flag");

endmodule : timer_capture_compare_channels
`default_nettype wire

// ### tb/pin_partner.sv
// Model of the outside signals at the timer channel pins
`timescale 1ns/100ps
`default_nettype none

module pin_partner
(
	input  wire logic [1:0] drive_en,
	input  wire logic [1:0] drive_lvl,
	input  wire logic [1:0] pin_out,
	input  wire logic [1:0] pin_oe,
	output var  logic [1:0] pin_in
);
	// Wire level: outside driver first, then block, else pull-up
	always_comb
	begin
		for (int i = 0; i < 2; i++)
			pin_in[i] = drive_en[i] ? drive_lvl[i]
				: (pin_oe[i] ? pin_out[i] : 1'b1);
	end
endmodule : pin_partner

`default_nettype wire

// ### tb/timer_capture_compare_channels_test.sv
// Self-checking bench for the capture/compare timer
`timescale 1ns/100ps
`default_nettype none

module timer_capture_compare_channels_test
	import timer_pkg::*;
;
	logic        core_clk;
	logic        rst_b;
	apb_req_t    req;
	apb_rsp_t    rsp;
	logic [1:0]  pin_in;
	logic [1:0]  pin_out;
	logic [1:0]  pin_oe;
	logic [1:0]  irq;
	logic [1:0]  drv_en;
	logic [1:0]  drv_lvl;
	logic        ext_clk;
	logic        err;
	logic [31:0] r;
	logic [31:0] c0;
	int          num_errors;
	int          checks_done;

	// ----------------------------------------------------------------
	// Clock, block and pin model
	// ----------------------------------------------------------------
	initial
	begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end

	// External clock driven by the bench for the pin-clocked rate
	timer_capture_compare_channels i_dut
	(
		.core_clk             (core_clk),
		.rst_b                (rst_b),
		.apb_req              (req),
		.apb_rsp              (rsp),
		.channel_pin_in       (pin_in),
		.external_timer_clock (ext_clk),
		.channel_pin_out      (pin_out),
		.channel_pin_oe       (pin_oe),
		.channel_irq          (irq)
	);

	pin_partner i_pins
	(
		.drive_en  (drv_en),
		.drive_lvl (drv_lvl),
		.pin_out   (pin_out),
		.pin_oe    (pin_oe),
		.pin_in    (pin_in)
	);

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic end_sim;
		if (num_errors == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : end_sim

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			num_errors++;
			$display("wrong value at %0t: got %h, want %h", $time, got, exp);
		end
	endtask : check

	// One APB transfer; request held until pready is seen
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [7:0] d);
		req.psel    <= 1'b1;
		req.penable <= 1'b0;
		req.pwrite  <= w;
		req.paddr   <= a;
		req.pwdata  <= {24'h0, d};
		@(posedge core_clk);
		req.penable <= 1'b1;
		do
			@(posedge core_clk);
		while (rsp.pready !== 1'b1);
		r = rsp.prdata;
		err = rsp.pslverr;
		req.psel    <= 1'b0;
		req.penable <= 1'b0;
		@(posedge core_clk);
	endtask : xfer

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		xfer(1'b1, a, d);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		xfer(1'b0, a, 8'h00);
		check(r, {24'h0, exp});
	endtask : rd

	// Flag clear: read arms, write of zero clears
	task automatic clr(input logic [7:0] a, input logic [7:0] cfg);
		xfer(1'b0, a, 8'h00);
		xfer(1'b1, a, cfg);
	endtask : clr

	task automatic edge_to(input logic v);
		drv_lvl[1] <= v;
		repeat (4) @(posedge core_clk);
	endtask : edge_to

	// High cycles of pin 0 over four periods of ten
	task automatic pwm_count(input int exp);
		int n;
		n = 0;
		repeat (30) @(posedge core_clk);
		repeat (40)
		begin
			@(negedge core_clk);
			n += pin_out[0];
		end
		check(n, exp);
	endtask : pwm_count

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial
	begin
		num_errors = 0;
		checks_done = 0;
		req = '0;
		drv_en = 2'b00;
		drv_lvl = 2'b00;
		ext_clk = 1'b0;
		rst_b = 1'b0;
		repeat (2) @(posedge core_clk);
		rst_b <= 1'b1;
		repeat (2) @(posedge core_clk);
		check(32'(pin_out), 32'h3);
		check(32'(pin_oe), 32'h0);
		rd(8'h0c, 8'h00);
		check(32'(err), 32'h0);
		xfer(1'b0, 8'h24, 8'h00);
		check(32'(err), 32'h1);
		wr(8'h0c, 8'h10);
		repeat (2) @(posedge core_clk);
		check(32'(pin_out[0]), 32'h0);
		// Window of 64 cycles holds exactly 64/divider ticks
		for (int p = 0; p < 7; p++)
		begin
			wr(8'h00, 8'(p));
			xfer(1'b0, 8'h04, 8'h00);
			c0 = r;
			repeat (61) @(posedge core_clk);
			xfer(1'b0, 8'h04, 8'h00);
			check(r - c0, 32'(64 >> p));
		end
		// Pin clock: ten toggles hold five rising edges
		wr(8'h00, 8'h07);
		xfer(1'b0, 8'h04, 8'h00);
		c0 = r;
		for (int k = 0; k < 10; k++)
		begin
			ext_clk <= ~ext_clk;
			@(posedge core_clk);
		end
		xfer(1'b0, 8'h04, 8'h00);
		check(r - c0, 32'd5);
		wr(8'h08, 8'h09);
		wr(8'h00, 8'h10);
		xfer(1'b0, 8'h04, 8'h00);
		c0 = r;
		repeat (37) @(posedge core_clk);
		xfer(1'b0, 8'h04, 8'h00);
		check(r, c0);
		check(32'(c0 < 32'd10), 32'h1);
		xfer(1'b0, 8'h00, 8'h00);
		check(32'(r[7]), 32'h1);
		// Every compare action, high write holding compares off
		for (int e = 0; e < 4; e++)
		begin
			wr(8'h00, 8'h20);
			wr(8'h0c, 8'h50 | 8'(e << 2));
			clr(8'h0c, 8'h50 | 8'(e << 2));
			check(32'(irq[0]), 32'h0);
			// High byte changed while the counter stands, low byte while it runs
			wr(8'h10, 8'h00);
			wr(8'h00, 8'h00);
			repeat (30) @(posedge core_clk);
			check(32'(irq[0]), 32'h0);
			wr(8'h14, 8'h05);
			repeat (30) @(posedge core_clk);
			check(32'(irq[0]), 32'h1);
			check(32'(pin_oe[0]), 32'(e != 0));
			if (e > 1)
				check(32'(pin_out[0]), 32'(e == 3));
		end
		wr(8'h14, 8'h05);
		wr(8'h0c, 8'h1a);
		pwm_count(20);
		wr(8'h10, 8'h00);
		wr(8'h14, 8'h00);
		pwm_count(20);
		wr(8'h10, 8'h00);
		wr(8'h14, 8'h05);
		wr(8'h0c, 8'h1b);
		pwm_count(40);
		wr(8'h18, 8'h1c);
		check(32'(pin_oe[1]), 32'h1);
		wr(8'h0c, 8'h28);
		check(32'(pin_oe[1]), 32'h0);
		// Buffered clear action: pin falls at the compare of five
		repeat (12) @(posedge core_clk);
		check(32'(pin_out[0]), 32'h0);
		wr(8'h0c, 8'h00);
		// Capture edges on channel 1, driven from outside
		drv_en <= 2'b10;
		for (int e = 1; e < 4; e++)
		begin
			wr(8'h00, 8'h30);
			wr(8'h18, 8'h40 | 8'(e << 2));
			wr(8'h00, 8'h00);
			clr(8'h18, 8'h40 | 8'(e << 2));
			edge_to(1'b1);
			check(32'(irq[1]), 32'(e & 1));
			clr(8'h18, 8'h40 | 8'(e << 2));
			edge_to(1'b0);
			check(32'(irq[1]), 32'(e >> 1));
		end
		// Slow ticks give a stable count of 3 at the edge
		wr(8'h00, 8'h16);
		repeat (220) @(posedge core_clk);
		edge_to(1'b1);
		rd(8'h1c, 8'h00);
		wr(8'h00, 8'h16);
		edge_to(1'b0);
		rd(8'h20, 8'h03);
		edge_to(1'b1);
		rd(8'h20, 8'h00);
		end_sim();
	end

	// Watchdog well past the expected 1500 or so cycles
	initial
	begin
		#100us;
		num_errors++;
		end_sim();
	end
endmodule : timer_capture_compare_channels_test

`default_nettype wire
